// *** inc/abs_pkg.sv ***
// package for the add bus input sharing block
// assumes nothing beyond a SystemVerilog compiler
package abs_pkg;
    // register offsets of the per channel line i/o control registers
    localparam logic [15:0] LINE_IO_CONTROL_CH0_OFS = 16'h1F01;
    localparam logic [15:0] LINE_IO_CONTROL_CH4_OFS = 16'h5F01;
    localparam logic [15:0] LINE_IO_CONTROL_CH8_OFS = 16'h9F01;
    localparam logic [7:0]  LINE_IO_CONTROL_RST     = 8'h00;
    // field position of the line clock edge select bit
    localparam int          EDGE_SEL_BIT            = 1;
    // pin positions on the shared byte
    localparam int          TRIB_DATA_LSB           = 2;
    localparam int          TRIB_CLOCK_LSB          = 5;
    localparam int          NUM_TRIB                = 3;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } abs_regreq_s;

    // state of the system clock side
    typedef struct packed {
        logic [2:0][7:0] io_ctrl;
        logic [7:0]      rdata;
        logic [1:0][7:0] add_sync;
        logic [7:0]      add_byte;
        logic [1:0][2:0] fall_sync;
        logic [1:0][2:0] rise_sync;
        logic [1:0][2:0] mode_sync;
        logic [2:0]      trib_bits;
        logic [1:0]      en_sync;
    } abs_state_s;
endpackage : abs_pkg

// *** rtl/abs_add_bus_share.sv ***
// shared add bus / tributary line input pins for channel 0
// assumes a simple register port on the system clock and live link clocks
//
// Notes on behaviour
// - pins act as add bus when bus enabled, tributary inputs when disabled
// - add byte captured on falling edge of add bus clock
// - pin bit 7 is byte msb, pin bit 0 is lsb
// - pins 2,3,4 are line data for tributaries 0,4,8 when bus disabled
// - pins 5,6,7 are line clocks for tributaries 0,4,8 when bus disabled
// - each tributary data is sampled only by its own line clock
// - default sampling is on falling edge of the line clock
// - edge select bit 1 set in ds3/e3 mode samples on rising edge
// - sts-1 mode always samples on falling edge
`timescale 1ns/100ps
`default_nettype none
module abs_add_bus_share (
    input  wire logic        CLK_SYS_IN,
    input  wire logic        RESET_N_IN,
    input  wire logic        ADD_BUS_CLOCK_CH0_IN,
    input  wire logic [7:0]  ADD_BUS_DATA_CH0_IN,
    input  wire logic        BUS_ENABLE_IN,
    input  wire logic [2:0]  STS1_MODE_IN,
    input  wire logic        REG_WR_IN,
    input  wire logic        REG_RD_IN,
    input  wire logic [15:0] REG_ADDR_IN,
    input  wire logic [7:0]  REG_WDATA_IN,
    output logic      [7:0]  REG_RDATA_OUT,
    output logic      [7:0]  ADD_BYTE_OUT,
    output logic      [2:0]  TRIB_LINE_DATA_OUT
);
    // ------------------------------------------------------------
    // state and local nets
    // ------------------------------------------------------------
    abs_pkg::abs_state_s    st_r;
    abs_pkg::abs_state_s    st_nxt;
    abs_pkg::abs_regreq_s   req;
    logic [7:0]             add_cap_r;
    logic [2:0]             trib_clk;
    logic [2:0]             trib_dat;
    logic [2:0]             fall_cap;
    logic [2:0]             rise_cap;
    logic [2:0]             wr_hit;
    logic                   rd_hit;

    // ------------------------------------------------------------
    // reset image of the system clock state
    // ------------------------------------------------------------
    localparam abs_pkg::abs_state_s ST_RESET = '{
        io_ctrl: {abs_pkg::NUM_TRIB{abs_pkg::LINE_IO_CONTROL_RST}},
        default: '0
    };

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    // index of the control register at an address, -1 when unmapped
    function automatic int reg_index(input logic [15:0] a);
        case (a)
            abs_pkg::LINE_IO_CONTROL_CH0_OFS: begin
                reg_index = 0;
            end
            abs_pkg::LINE_IO_CONTROL_CH4_OFS: begin
                reg_index = 1;
            end
            abs_pkg::LINE_IO_CONTROL_CH8_OFS: begin
                reg_index = 2;
            end
            default: begin
                reg_index = -1;
            end
        endcase
    endfunction

    // one bit per control register, set when the address selects it
    function automatic logic [2:0] reg_select(input logic [15:0] a);
        logic [2:0] sel;
        sel = 3'h0;
        case (reg_index(a))
            0: begin
                sel = 3'h1;
            end
            1: begin
                sel = 3'h2;
            end
            2: begin
                sel = 3'h4;
            end
            default: begin
                sel = 3'h0;
            end
        endcase
        reg_select = sel;
    endfunction

    // rising edge only when the invert bit is set and the channel is not sts-1
    function automatic logic use_rising(input logic [7:0] ctrl,
                                        input logic       sts1_mode);
        logic rising;
        rising = 1'b0;
        if (ctrl[abs_pkg::EDGE_SEL_BIT]) begin
            rising = 1'b1;
        end
        if (sts1_mode) begin
            rising = 1'b0;
        end
        use_rising = rising;
    endfunction

    // ------------------------------------------------------------
    // register request carrier
    // ------------------------------------------------------------
    assign req.wr    = REG_WR_IN;
    assign req.rd    = REG_RD_IN;
    assign req.addr  = REG_ADDR_IN;
    assign req.wdata = REG_WDATA_IN;

    // unmapped addresses select nothing, so writes to them are dropped
    assign wr_hit = req.wr ? reg_select(req.addr) : 3'h0;
    assign rd_hit = req.rd && (reg_index(req.addr) >= 0);

    // ------------------------------------------------------------
    // add bus capture, add clock domain
    // ------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_add_bit
            logic add_q;
            // pin b lands on byte bit b: pin 7 is the msb, pin 0 the lsb
            always_ff @(negedge ADD_BUS_CLOCK_CH0_IN or negedge RESET_N_IN) begin
                if (!RESET_N_IN) begin
                    add_q <= 1'b0;
                end else if (BUS_ENABLE_IN) begin
                    add_q <= ADD_BUS_DATA_CH0_IN[b];
                end
            end
            assign add_cap_r[b] = add_q;
        end
    endgenerate

    // ------------------------------------------------------------
    // shared pin split for the tributary role
    // ------------------------------------------------------------
    assign trib_clk = ADD_BUS_DATA_CH0_IN[abs_pkg::TRIB_CLOCK_LSB +: abs_pkg::NUM_TRIB];
    assign trib_dat = ADD_BUS_DATA_CH0_IN[abs_pkg::TRIB_DATA_LSB +: abs_pkg::NUM_TRIB];

    // ------------------------------------------------------------
    // tributary capture, one line clock per channel
    // ------------------------------------------------------------
    // both edges are always captured; the choice is made on the system
    // clock side, so a change of the invert bit never glitches a line clock
    genvar g;
    generate
        for (g = 0; g < abs_pkg::NUM_TRIB; g++) begin : g_trib
            logic fall_q;
            logic rise_q;

            always_ff @(negedge trib_clk[g] or negedge RESET_N_IN) begin
                if (!RESET_N_IN) begin
                    fall_q <= 1'b0;
                end else begin
                    fall_q <= trib_dat[g];
                end
            end

            always_ff @(posedge trib_clk[g] or negedge RESET_N_IN) begin
                if (!RESET_N_IN) begin
                    rise_q <= 1'b0;
                end else begin
                    rise_q <= trib_dat[g];
                end
            end

            assign fall_cap[g] = fall_q;
            assign rise_cap[g] = rise_q;
        end
    endgenerate

    // ------------------------------------------------------------
    // system clock side, next state
    // ------------------------------------------------------------
    always_comb begin
        int         idx;
        logic [2:0] pick;
        idx    = reg_index(req.addr);
        pick   = 3'h0;
        st_nxt = st_r;

        // two flop synchronisers: the first stage is read only by the second
        st_nxt.add_sync  = {st_r.add_sync[0], add_cap_r};
        st_nxt.fall_sync = {st_r.fall_sync[0], fall_cap};
        st_nxt.rise_sync = {st_r.rise_sync[0], rise_cap};
        st_nxt.mode_sync = {st_r.mode_sync[0], STS1_MODE_IN};
        st_nxt.en_sync   = {st_r.en_sync[0], BUS_ENABLE_IN};

        // sampling edge chosen per channel from its own control register
        for (int k = 0; k < abs_pkg::NUM_TRIB; k++) begin
            if (use_rising(st_r.io_ctrl[k], st_r.mode_sync[1][k])) begin
                pick[k] = st_r.rise_sync[1][k];
            end else begin
                pick[k] = st_r.fall_sync[1][k];
            end
        end

        // only the role picked by the enable updates its output
        if (st_r.en_sync[1]) begin
            st_nxt.add_byte = st_r.add_sync[1];
        end else begin
            st_nxt.trib_bits = pick;
        end

        // control register writes
        for (int k = 0; k < abs_pkg::NUM_TRIB; k++) begin
            if (wr_hit[k]) begin
                st_nxt.io_ctrl[k] = req.wdata;
            end
        end

        // read data holds until the next read
        if (req.rd) begin
            if (rd_hit) begin
                st_nxt.rdata = st_r.io_ctrl[idx[1:0]];
            end else begin
                st_nxt.rdata = 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // system clock side, state register
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs, straight from the state register
    // ------------------------------------------------------------
    assign REG_RDATA_OUT      = st_r.rdata;
    assign ADD_BYTE_OUT       = st_r.add_byte;
    assign TRIB_LINE_DATA_OUT = st_r.trib_bits;
endmodule // abs_add_bus_share
`default_nettype wire

// *** bench/abs_line_model.sv ***
// line side model: add bus source or three tributary line units
// assumes lclk_in runs free
`timescale 1ns/100ps
`default_nettype none
module abs_line_model (
    input  wire logic       lclk_in,
    input  wire logic       en_in,
    input  wire logic [7:0] byte_in,
    input  wire logic [2:0] dat_in,
    output logic      [7:0] pins_out,
    output logic            aclk_out
);
    // add clock stands still outside bus mode
    assign aclk_out = en_in & lclk_in;
    logic ph = 1'b0;
    // line data flips a quarter period after each clock edge: rising sees dat, falling sees its inverse
    always @(lclk_in) ph <= #12 lclk_in;
    assign pins_out = en_in ? byte_in : {{3{lclk_in}}, dat_in ^ {3{ph}}, ~byte_in[1:0]};
endmodule // abs_line_model
`default_nettype wire

// *** bench/abs_add_bus_share_properties.sv ***
// checker for the add bus sharing block
// assumes a bind onto abs_add_bus_share
`timescale 1ns/100ps
`default_nettype none
module abs_add_bus_share_properties (
    input wire logic        CLK_SYS_IN,
    input wire logic        RESET_N_IN,
    input wire logic        BUS_ENABLE_IN,
    input wire logic        REG_WR_IN,
    input wire logic        REG_RD_IN,
    input wire logic [15:0] REG_ADDR_IN,
    input wire logic [7:0]  REG_WDATA_IN,
    input wire logic [7:0]  REG_RDATA_OUT,
    input wire logic [7:0]  ADD_BYTE_OUT,
    input wire logic [2:0]  TRIB_LINE_DATA_OUT
);
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RESET_N_IN);
    logic mapped;
    assign mapped = REG_ADDR_IN inside {16'h1F01, 16'h5F01, 16'h9F01};
    sequence s_wr(a); REG_WR_IN && !REG_RD_IN && REG_ADDR_IN == a; endsequence
    sequence s_rd(a); REG_RD_IN && !REG_WR_IN && REG_ADDR_IN == a; endsequence
    property p_rb(a); s_wr(a) ##1 s_rd(a) |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 2); endproperty
    rb_ch0_a: assert property (p_rb(16'h1F01)) else $error("ch0 readback wrong");
    rb_ch4_a: assert property (p_rb(16'h5F01)) else $error("ch4 readback wrong");
    rb_ch8_a: assert property (p_rb(16'h9F01)) else $error("ch8 readback wrong");
    rd_unmapped_a: assert property (REG_RD_IN && !mapped |=> REG_RDATA_OUT == 8'h00) else $error("unmapped read");
    rd_hold_a: assert property (!REG_RD_IN |=> $stable(REG_RDATA_OUT)) else $error("read data moved");
    reset_vals_a: assert property ($rose(RESET_N_IN) |-> {REG_RDATA_OUT, ADD_BYTE_OUT} == 16'h0000) else $error("reset");
    add_frozen_a: assert property (!BUS_ENABLE_IN [*6] |=> $stable(ADD_BYTE_OUT)) else $error("add byte moved");
    trib_frozen_a: assert property (BUS_ENABLE_IN [*6] |=> $stable(TRIB_LINE_DATA_OUT)) else $error("trib moved");
endmodule // abs_add_bus_share_properties
`default_nettype wire

// *** bench/abs_add_bus_share_tb_top.sv ***
// testbench for the add bus sharing block
// assumes design, line model and checker compiled first
`timescale 1ns/100ps
`default_nettype none
module add_bus_line_input_sharing_tb_top;
    logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, en = 1'b0, wr = 1'b0, rd = 1'b0, aclk;
    logic [2:0] sts = 3'h0, dat = 3'h0, trib;
    logic [7:0] byt = 8'h00, wd = 8'h00, rdo, addo, pins;
    logic [15:0] adr = 16'h0000;
    logic [15:0] ofs [3] = '{16'h1F01, 16'h5F01, 16'h9F01};
    logic [31:0] r = 32'h679AF16F;
    logic [9:0] q [$];
    logic [9:0] n;
    logic [7:0] ctl [3];
    logic [7:0] e;
    int errors = 0, num_checks = 0;
    event ev;
    initial forever #12.5 clk = ~clk;
    initial begin #7; forever #24 lclk = ~lclk; end
    abs_line_model u_liu (.lclk_in(lclk), .en_in(en), .byte_in(byt), .dat_in(dat), .pins_out(pins), .aclk_out(aclk));
    abs_add_bus_share u_dut (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .ADD_BUS_CLOCK_CH0_IN(aclk),
        .ADD_BUS_DATA_CH0_IN(pins), .BUS_ENABLE_IN(en), .STS1_MODE_IN(sts), .REG_WR_IN(wr), .REG_RD_IN(rd),
        .REG_ADDR_IN(adr), .REG_WDATA_IN(wd), .REG_RDATA_OUT(rdo), .ADD_BYTE_OUT(addo), .TRIB_LINE_DATA_OUT(trib));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic test_done();
        if (errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin errors++; $display("CHECK FAILED %0t seen %h want %h", $time, s, e); end
    endtask
    // optional write, then a read whose expected value is noted
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [7:0] e);
        @(negedge clk); wr = w; adr = a; wd = d;
        @(negedge clk); wr = 1'b0; rd = 1'b1;
        @(negedge clk); rd = 1'b0; q.push_back({2'd0, e}); ->ev;
    endtask
    task automatic obs(input logic [1:0] s, input logic [7:0] e);
        repeat (12) @(negedge clk);
        q.push_back({s, e}); ->ev;
    endtask
    initial forever begin
        @(ev);
        while (q.size() > 0) begin
            n = q.pop_front();
            case (n[9:8])
                2'd0: chk(rdo, n[7:0]);
                2'd1: chk(addo, n[7:0]);
                default: chk({5'h00, trib}, n[7:0]);
            endcase
        end
    end
    initial begin #100000; errors++; test_done(); end
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        obs(2'd1, 8'h00);
        for (int i = 0; i < 3; i++) begin
            r = lfsr(r);
            acc(1'b0, ofs[i], 8'h00, abs_pkg::LINE_IO_CONTROL_RST);
            acc(1'b1, ofs[i], r[7:0], r[7:0]);
            ctl[i] = r[7:0];
        end
        acc(1'b1, 16'h1F02, 8'hFF, 8'h00);
        acc(1'b0, ofs[2], 8'h00, r[7:0]);
        en = 1'b1;
        for (int i = 0; i < 4; i++) begin r = lfsr(r); byt = r[7:0]; obs(2'd1, r[7:0]); end
        en = 1'b0;
        for (int i = 0; i < 6; i++) begin
            r = lfsr(r);
            ctl[i % 3] = {r[15:10], i[0], r[8]};
            acc(1'b1, ofs[i % 3], ctl[i % 3], ctl[i % 3]);
            dat = r[2:0]; sts = (i < 3) ? 3'h0 : r[5:3]; byt = r[23:16];
            e = 8'h00;
            for (int k = 0; k < 3; k++) e[k] = (ctl[k][abs_pkg::EDGE_SEL_BIT] && !sts[k]) ? dat[k] : ~dat[k];
            obs(2'd2, e);
        end
        test_done();
    end
endmodule // add_bus_line_input_sharing_tb_top
bind abs_add_bus_share abs_add_bus_share_properties u_props (.*);
`default_nettype wire
